// ---- inc/plsr_pkg.sv ----
// ---------------------------------------------------------------------------
// Shared constants and carriers of the parallel-load shift register.
// ---------------------------------------------------------------------------
package plsr_pkg;

    // Number of register stages.
    localparam int STAGES = 8;
    // Flip-flops that each pin input passes before use.
    localparam int SYNC_DEPTH = 3;
    // Words held by the shift-event queue.
    localparam int QUEUE_DEPTH = 8;
    // Reset value of every synchroniser and filter flip-flop except the load pin's.
    localparam logic SYNC_RST_VAL = 1'h0;
    // Reset value of the load pin's flops: its idle, inactive level.
    localparam logic NLOAD_RST_VAL = 1'h1;
    // Reset value of the queue pointers and count.
    localparam logic [7:0] QUEUE_RST_VAL = 8'h00;

    // Pin group as seen after synchronising and filtering.
    typedef struct packed {
        logic [STAGES-1:0] par_data;
        logic serial_in;
        logic clock_inhibit;
        logic clock;
        logic shift_nload;
    } plsr_pins_t;

    // One queued shift: the serial bit that enters the first stage.
    typedef struct packed {
        logic serial_in;
    } plsr_shift_t;

    localparam int PIN_W = $bits(plsr_pins_t);
    localparam int SHIFT_W = $bits(plsr_shift_t);

endpackage : plsr_pkg

// ---- verilog/plsr_top.sv ----
`timescale 1ns/10ps

// ---------------------------------------------------------------------------
// Parameterised queue with valid/ready on both sides.
// ---------------------------------------------------------------------------
module plsr_fifo
    import plsr_pkg::*;
#(
    parameter int WIDTH = SHIFT_W,
    parameter int DEPTH = QUEUE_DEPTH
) (
    // Clock, reset and enable.
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    input wire logic i_flush,
    // Filling side.
    input wire logic i_wr_valid,
    input wire logic [WIDTH-1:0] i_wr_data,
    output logic o_wr_ready,
    // Draining side.
    output logic o_rd_valid,
    output logic [WIDTH-1:0] o_rd_data,
    input wire logic i_rd_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic [AW-1:0] wr_ptr_next;
    logic [AW-1:0] rd_ptr_next;
    logic [AW:0] count_next;
    wire push;
    wire pop;

    // Full and empty come straight from the occupancy count.
    assign o_wr_ready = (count_reg != DEPTH_C);
    assign o_rd_valid = (count_reg != '0);
    assign o_rd_data = mem[rd_ptr_reg];
    assign push = i_ce && i_wr_valid && o_wr_ready;
    assign pop = i_ce && o_rd_valid && i_rd_ready;
    assign wr_ptr_next = (wr_ptr_reg == LAST_C) ? '0 : wr_ptr_reg + 1'b1;
    assign rd_ptr_next = (rd_ptr_reg == LAST_C) ? '0 : rd_ptr_reg + 1'b1;

    // Occupancy after this cycle's push and pop.
    always_comb begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    // Storage needs no reset; only words below the count are ever read.
    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= i_wr_data;
        end
    end

    // Pointers and count; a flush empties the queue at once.
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wr_ptr_reg <= QUEUE_RST_VAL[AW-1:0];
            rd_ptr_reg <= QUEUE_RST_VAL[AW-1:0];
            count_reg <= QUEUE_RST_VAL[AW:0];
        end else if (i_ce && i_flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_next;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_next;
            end
            count_reg <= count_next;
        end
    end

endmodule : plsr_fifo

// ---------------------------------------------------------------------------
// Shift register core with pin conditioning.
// ---------------------------------------------------------------------------
module plsr_top
    import plsr_pkg::*;
#(
    parameter int N_STAGES = STAGES,
    parameter int Q_DEPTH = QUEUE_DEPTH
) (
    // Clock, reset and enable.
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    // Device pins, asynchronous to i_ref_clk.
    input wire logic i_shift_nload,
    input wire logic i_clock,
    input wire logic i_clock_inhibit,
    input wire logic i_serial_in,
    input wire logic [N_STAGES-1:0] i_par_data,
    // Drain control for the shift-event queue.
    input wire logic i_shift_ready,
    // Serial outputs and status.
    output logic o_serial_out,
    output logic o_serial_out_inverted,
    output logic o_queue_ready,
    output logic o_shift_lost
);
    localparam int PW = N_STAGES + 4;

    logic [PW-1:0] pins_raw;
    logic [PW-1:0] filt_reg;
    logic [PW-1:0] filt_prev_reg;
    logic [N_STAGES-1:0] stage_reg;
    logic [N_STAGES-1:0] stage_next;
    logic q_wr_ready;
    logic q_rd_valid;
    logic [SHIFT_W-1:0] q_rd_data;
    plsr_shift_t q_head;
    wire load_active;
    wire clk_rise;
    wire inh_rise;
    wire shift_event;
    wire shift_take;

    assign pins_raw = {i_par_data, i_serial_in, i_clock_inhibit, i_clock,
                       i_shift_nload};

    // Each pin passes three flops; the filter moves only when the second
    // and third agree, so a single-cycle glitch never reaches the core.
    for (genvar b = 0; b < PW; b++) begin : g_sync
        // The load pin idles high, so its flops reset high; a zero there
        // would read as a parallel load straight after reset.
        localparam logic RST_B = (b == 0) ? NLOAD_RST_VAL : SYNC_RST_VAL;
        logic [SYNC_DEPTH-1:0] sync_reg;
        always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                sync_reg <= {SYNC_DEPTH{RST_B}};
                filt_reg[b] <= RST_B;
                filt_prev_reg[b] <= RST_B;
            end else if (i_ce) begin
                sync_reg <= {sync_reg[SYNC_DEPTH-2:0], pins_raw[b]};
                if (sync_reg[1] == sync_reg[2]) begin
                    filt_reg[b] <= sync_reg[2];
                end
                filt_prev_reg[b] <= filt_reg[b];
            end
        end
    end

    // Edge decode on the filtered pins; clock and inhibit are symmetric.
    assign load_active = !filt_reg[0];
    assign clk_rise = filt_reg[1] && !filt_prev_reg[1]
                      && !filt_reg[2];
    assign inh_rise = filt_reg[2] && !filt_prev_reg[2]
                      && !filt_reg[1];
    // Raising inhibit while clock is low is itself a shift, so the
    // controller must raise it only with clock high.
    assign shift_event = !load_active && (clk_rise || inh_rise);

    // Shifts wait in the queue until the drain side accepts them.
    plsr_fifo #(
        .WIDTH(SHIFT_W),
        .DEPTH(Q_DEPTH)
    ) u_queue (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .i_flush(load_active),
        .i_wr_valid(shift_event),
        .i_wr_data(filt_reg[3]),
        .o_wr_ready(q_wr_ready),
        .o_rd_valid(q_rd_valid),
        .o_rd_data(q_rd_data),
        .i_rd_ready(i_shift_ready)
    );

    assign q_head = plsr_shift_t'(q_rd_data);
    assign shift_take = q_rd_valid && i_shift_ready && !load_active;

    // Next stage contents: load wins, then a queued shift, else hold.
    always_comb begin
        stage_next = stage_reg;
        if (load_active) begin
            stage_next = filt_reg[PW-1:4];
        end else if (shift_take) begin
            stage_next = {stage_reg[N_STAGES-2:0], q_head.serial_in};
        end
    end

    // Stages carry no reset, as the device they model has none.
    always_ff @(posedge i_ref_clk) begin
        if (i_ce) begin
            stage_reg <= stage_next;
            o_serial_out <= stage_next[N_STAGES-1];
            o_serial_out_inverted <= !stage_next[N_STAGES-1];
        end
    end

    // Queue status; a lost shift stays flagged until the next load.
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_queue_ready <= 1'h0;
            o_shift_lost <= 1'h0;
        end else if (i_ce) begin
            o_queue_ready <= q_wr_ready;
            if (shift_event && !q_wr_ready) begin
                o_shift_lost <= 1'h1;
            end else if (load_active) begin
                o_shift_lost <= 1'h0;
            end
        end
    end

endmodule : plsr_top

// ---- tb/plsr_props.sv ----
`timescale 1ns/10ps
// ----------------
// Port checker.
// ----------------
module plsr_top_chk
    import plsr_pkg::*;
#(
    parameter int N_STAGES = STAGES,
    parameter int Q_DEPTH = QUEUE_DEPTH
) (
    // Clock, reset and pins.
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    input wire logic i_shift_nload,
    input wire logic i_clock,
    input wire logic i_clock_inhibit,
    input wire logic i_serial_in,
    input wire logic [N_STAGES-1:0] i_par_data,
    input wire logic i_shift_ready,
    // Outputs.
    input wire logic o_serial_out,
    input wire logic o_serial_out_inverted,
    input wire logic o_queue_ready,
    input wire logic o_shift_lost
);
    // Stages are unknown until a load has passed the pin filter, so
    // output checks wait for six low samples of the load pin.
    logic [2:0] low_cnt;
    logic primed;
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            low_cnt <= 3'h0;
            primed <= 1'b0;
        end else begin
            low_cnt <= i_shift_nload ? 3'h0
                : low_cnt + {2'h0, low_cnt != 3'h7};
            primed <= primed | (low_cnt >= 3'h6);
        end
    end
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_load;
        (!i_shift_nload && $stable(i_par_data))[*6];
    endsequence
    sequence s_idle(logic c);
        (primed && i_shift_nload && i_shift_ready && c)[*8];
    endsequence
    chk_inv_output: assert property (primed |->
        o_serial_out_inverted != o_serial_out) else $error("inverse bad");
    chk_load_copies: assert property (s_load |->
        o_serial_out == i_par_data[N_STAGES-1]) else $error("load bad");
    chk_load_flush: assert property (s_load |=>
        o_queue_ready && !o_shift_lost) else $error("flush bad");
    chk_clock_high: assert property (s_idle(i_clock) |=>
        ##1 $stable(o_serial_out)) else $error("moved, clock high");
    chk_inhibit_high: assert property (s_idle(i_clock_inhibit) |=>
        ##1 $stable(o_serial_out)) else $error("moved, inhibit");
    chk_quiet_hold: assert property (s_idle($stable({i_clock,
        i_clock_inhibit})) |=> ##1 $stable(o_serial_out))
        else $error("moved, no edge");
    chk_lost_cause: assert property ($rose(o_shift_lost) |->
        !$past(o_queue_ready) || !$past(o_queue_ready, 2))
        else $error("lost with room");
    chk_lost_sticky: assert property (
        i_shift_nload[*5] ##0 o_shift_lost |=> o_shift_lost)
        else $error("lost cleared");
endmodule : plsr_top_chk

// ---- tb/plsr_ctrl_model.sv ----
`timescale 1ns/10ps
// ----------------
// Pin controller.
// ----------------
module plsr_ctrl_model (
    // Clock.
    input wire logic i_ref_clk,
    // Pins.
    output logic o_nload = 1'b1,
    output logic o_clk = 1'b0,
    output logic o_inh = 1'b0,
    output logic o_ser = 1'b0,
    output logic [7:0] o_par = 8'h00
);
    // Levels last at least four cycles; the pin filter may miss one.
    task automatic hold(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask : hold
    // Stale direct inputs are inverted, never left at the loaded value.
    task automatic load(input logic [7:0] d);
        o_par = d;
        o_nload = 1'b0;
        hold(8);
        o_nload = 1'b1;
        hold(4);
        o_par = ~d;
    endtask : load
    // Inhibit rising with the clock low is a shift edge as well.
    task automatic shift(input logic b, input logic by_inh);
        o_ser = b;
        if (by_inh) o_inh = 1'b1;
        else o_clk = 1'b1;
        hold(4);
        o_clk = 1'b0;
        o_inh = 1'b0;
        o_ser = ~b;
        hold(4);
    endtask : shift
    // The first clock rise shifts once; the pulse under inhibit must not.
    task automatic blocked();
        o_clk = 1'b1;
        hold(4);
        o_inh = 1'b1;
        hold(4);
        o_clk = 1'b0;
        hold(4);
        o_clk = 1'b1;
        hold(4);
        o_inh = 1'b0;
        o_clk = 1'b0;
        hold(4);
    endtask : blocked
endmodule : plsr_ctrl_model

// ---- tb/test_parallel_load_shift_register.sv ----
`timescale 1ns/10ps
// ----------------
// Bench.
// ----------------
module test_parallel_load_shift_register;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rdy = 1'b1;
    logic nl, ck, ih, sr, so, si, qr, ls;
    logic [7:0] par;
    int mismatches = 0;
    int checks_done = 0;
    always #50 clk = ~clk;
    plsr_ctrl_model u_ctrl (.i_ref_clk(clk), .o_nload(nl), .o_clk(ck),
        .o_inh(ih), .o_ser(sr), .o_par(par));
    plsr_top u_dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_ce(1'b1),
        .i_shift_nload(nl), .i_clock(ck), .i_clock_inhibit(ih),
        .i_serial_in(sr), .i_par_data(par), .i_shift_ready(rdy),
        .o_serial_out(so), .o_serial_out_inverted(si),
        .o_queue_ready(qr), .o_shift_lost(ls));
    task automatic check(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    // Bit k of d lands after 7-k shifts, then serial bits follow.
    task automatic t_shift();
        logic [7:0] d;
        logic [15:0] s;
        d = 8'h4d;
        s = 16'hc3a5;
        u_ctrl.load(d);
        check(so, d[7]);
        check(si, !d[7]);
        for (int k = 0; k < 15; k++) begin
            u_ctrl.shift(s[k], k[0]);
            check(so, k < 7 ? d[6 - k] : s[k - 7]);
        end
        $display("t_shift end");
    endtask : t_shift
    // Exactly one shift from the blocked pulse brings bit 6 to the output.
    task automatic t_inhibit();
        u_ctrl.load(8'h40);
        u_ctrl.blocked();
        check(so, 1'b1);
        u_ctrl.shift(1'b0, 1'b0);
        check(so, 1'b0);
        $display("t_inhibit end");
    endtask : t_inhibit
    // Nine shifts against a stalled queue of eight drop one.
    task automatic t_stall();
        u_ctrl.load(8'h00);
        rdy = 1'b0;
        repeat (9) u_ctrl.shift(1'b1, 1'b0);
        check(so, 1'b0);
        check(qr, 1'b0);
        check(ls, 1'b1);
        rdy = 1'b1;
        u_ctrl.hold(12);
        check(so, 1'b1);
        u_ctrl.load(8'h01);
        check(ls, 1'b0);
        check(so, 1'b0);
        $display("t_stall end");
    endtask : t_stall
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        t_shift();
        t_inhibit();
        t_stall();
        final_report();
    end
    // The tests need under a thousand cycles.
    initial begin
        #(3000 * 100);
        mismatches++;
        final_report();
    end
endmodule : test_parallel_load_shift_register
bind plsr_top plsr_top_chk #(.N_STAGES(N_STAGES), .Q_DEPTH(Q_DEPTH)) u_chk (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
    .i_shift_nload(i_shift_nload), .i_clock(i_clock),
    .i_clock_inhibit(i_clock_inhibit), .i_serial_in(i_serial_in),
    .i_par_data(i_par_data), .i_shift_ready(i_shift_ready),
    .o_serial_out(o_serial_out), .o_queue_ready(o_queue_ready),
    .o_serial_out_inverted(o_serial_out_inverted),
    .o_shift_lost(o_shift_lost));
